//--- tb/test_tsms_top.sv
`timescale 1ns/100ps
`include "tsms_cfg.svh"
// Self-checking bench for the two-speed sequencer
module test_tsms_top;
    localparam int unsigned N = 4;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    tsms_pkg::tsms_bus_s bus = '0;
    logic [31:0]         rdata;
    logic [5:0]          req = 6'h00;
    logic [5:0]          logic_in;
    logic                key_aux1 = 1'b0, key_aux2 = 1'b0, key_stop = 1'b0;
    logic                low_voltage = 1'b0, diag_err = 1'b0, warn_in = 1'b0;
    logic                out_low_speed, out_high_speed, out_warning, out_fault_relay, irq;
    logic [15:0]         flc_active, flc_lo, flc_hi;
    logic                motor_low, motor_high, re_d = 1'b0;
    logic [31:0]         exp_q[$];
    int                  miscompares = 0, n_tests = 0, cycles = 0, seed = 2566;

    // 125 MHz clock
    always #4 clk = ~clk;

    tsms_top #(.TICK_CYCLES(N)) i_tsms_top (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
        .logic_in(logic_in), .key_aux1(key_aux1), .key_aux2(key_aux2), .key_stop(key_stop),
        .low_voltage(low_voltage), .diag_err(diag_err), .warn_in(warn_in),
        .out_low_speed(out_low_speed), .out_high_speed(out_high_speed),
        .out_warning(out_warning), .out_fault_relay(out_fault_relay),
        .flc_active(flc_active), .irq(irq));

    tsms_partner i_tsms_partner (.clk(clk), .srst(srst), .req(req), .coil_low(out_low_speed),
        .coil_high(out_high_speed), .logic_in(logic_in), .motor_low(motor_low),
        .motor_high(motor_high));

    // Verdict and end of run
    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Word compare
    task automatic chk_word(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Single output compare
    task automatic chk_bit(logic got, logic exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask

    // Register write: one cycle strobe
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus.we <= 1'b0;
    endtask

    // Register read: expectation queued for the watcher
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus.re <= 1'b0;
    endtask

    function automatic logic sp(bit hi);
        return hi ? out_high_speed : out_low_speed;
    endfunction

    // Bounded wait for a speed output level; returns on a rising edge
    task automatic wait_out(bit hi, logic v, int lim);
        int k;
        #1;
        for (k = 0; k < lim && sp(hi) !== v; k++)
        begin
            @(posedge clk);
            #1;
        end
        chk_bit(sp(hi), v);
        @(posedge clk);
    endtask

    // Output must keep its level for n cycles
    task automatic hold(bit hi, logic v, int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            chk_bit(sp(hi), v);
        end
        @(posedge clk);
    endtask

    // Keypad pulse of one cycle
    task automatic tap(int which);
        @(posedge clk);
        if (which == 1)
            key_aux1 <= 1'b1;
        else
            key_aux2 <= 1'b1;
        @(posedge clk);
        key_aux1 <= 1'b0;
        key_aux2 <= 1'b0;
    endtask

    // Read-data watcher, interlock watch and hang limit
    always @(posedge clk)
    begin
        if (re_d)
            chk_word(rdata, exp_q.pop_front());
        re_d <= bus.re;
        if (!srst)
            chk_bit(out_low_speed & out_high_speed, 1'b0);
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`TSMS_OFF_CTRL, 32'h0);
        rd(`TSMS_OFF_TIMEOUT, 32'h1);
        rd(`TSMS_OFF_FLC_LOW, 32'h64);
        rd(`TSMS_OFF_FLC_HIGH, 32'h64);
        rd(`TSMS_OFF_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0);
        chk_bit(out_fault_relay, 1'b1);
        wr(`TSMS_OFF_TIMEOUT, 32'h3FFF);
        rd(`TSMS_OFF_TIMEOUT, {18'h0, `TSMS_TMO_MAX});
        wr(`TSMS_OFF_TIMEOUT, 32'h2);
        flc_lo = 16'($random(seed));
        flc_hi = 16'($random(seed));
        wr(`TSMS_OFF_FLC_LOW, {16'h0, flc_lo});
        wr(`TSMS_OFF_FLC_HIGH, {16'h0, flc_hi});
        // Terminal strip, maintained: I1 low, stop, timeout, then I2 high
        req <= 6'h01;
        wait_out(0, 1'b1, 8);
        chk_word({16'h0, flc_active}, {16'h0, flc_lo});
        req <= 6'h00;
        wait_out(0, 1'b0, 4);
        req <= 6'h02;
        hold(1, 1'b0, 2 * N + 2);
        wait_out(1, 1'b1, 12);
        chk_word({16'h0, flc_active}, {16'h0, flc_hi});
        low_voltage <= 1'b1;
        wait_out(1, 1'b0, 2);
        low_voltage <= 1'b0;
        req <= 6'h00;
        repeat (3 * N + 6) @(posedge clk);
        // Diagnostic fault with interrupt unmasked, raised and cleared
        req <= 6'h01;
        wait_out(0, 1'b1, 12);
        wr(`TSMS_OFF_IRQ_STAT, 32'hF);
        wr(`TSMS_OFF_IRQ_MASK, 32'h1);
        diag_err <= 1'b1;
        wait_out(0, 1'b0, 2);
        chk_bit(out_fault_relay, 1'b0);
        chk_bit(irq, 1'b1);
        rd(`TSMS_OFF_IRQ_STAT, 32'h1);
        wr(`TSMS_OFF_IRQ_STAT, 32'h1);
        #1;
        chk_bit(irq, 1'b0);
        @(posedge clk);
        diag_err <= 1'b0;
        req <= 6'h00;
        repeat (3 * N + 6) @(posedge clk);
        // Network channel with direct transition
        wr(`TSMS_OFF_CTRL, 32'h1);
        wr(`TSMS_OFF_TIMEOUT, 32'h5);
        wr(`TSMS_OFF_NETCMD, 32'h3);
        req <= 6'h20;
        wait_out(0, 1'b1, 12);
        wr(`TSMS_OFF_NETCMD, 32'h1);
        wait_out(0, 1'b0, 4);
        hold(1, 1'b0, N + 1);
        wait_out(1, 1'b1, N + 6);
        wr(`TSMS_OFF_NETCMD, 32'h3);
        wait_out(1, 1'b0, 4);
        hold(0, 1'b0, 5 * N + 1);
        wait_out(0, 1'b1, 12);
        wr(`TSMS_OFF_NETCMD, 32'h0);
        req <= 6'h00;
        repeat (6 * N + 8) @(posedge clk);
        // Keypad impulse wiring
        wr(`TSMS_OFF_CTRL, 32'h6);
        tap(2);
        wait_out(1, 1'b1, 6);
        wr(`TSMS_OFF_IRQ_STAT, 32'hF);
        hold(1, 1'b1, 4);
        key_stop <= 1'b1;
        @(posedge clk);
        key_stop <= 1'b0;
        wait_out(1, 1'b0, 4);
        tap(1);
        hold(0, 1'b0, 5 * N + 6);
        key_stop <= 1'b1;
        tap(1);
        hold(0, 1'b0, 6);
        rd(`TSMS_OFF_IRQ_STAT, 32'h8);
        key_stop <= 1'b0;
        repeat (2) @(posedge clk);
        tap(1);
        wait_out(0, 1'b1, 6);
        // I3 copied to memory only, warning passed through
        wr(`TSMS_OFF_CTRL, 32'hE);
        req <= 6'h04;
        warn_in <= 1'b1;
        repeat (3) @(posedge clk);
        chk_bit(out_warning, 1'b1);
        rd(`TSMS_OFF_STATUS, 32'hE5);
        chk_bit(out_low_speed, 1'b1);
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule

//--- tb/tsms_partner.sv
`timescale 1ns/100ps
// Operator terminal strip and contactor stand-in on the motor side
module tsms_partner (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [5:0] req,
    input  wire logic       coil_low,
    input  wire logic       coil_high,
    output logic [5:0]      logic_in,
    output logic            motor_low,
    output logic            motor_high
);
    // Terminal levels follow the operator; I6 picks local or remote
    always @(posedge clk)
    begin
        logic_in   <= srst ? 6'h00 : req;
        motor_low  <= coil_low;
        motor_high <= coil_high;
    end
endmodule

//--- verilog/tsms_cfg.svh
`ifndef TSMS_CFG_SVH
`define TSMS_CFG_SVH

// Register byte offsets
`define TSMS_ADDR_W        8
`define TSMS_OFF_CTRL      8'h00
`define TSMS_OFF_TIMEOUT   8'h04
`define TSMS_OFF_FLC_LOW   8'h08
`define TSMS_OFF_FLC_HIGH  8'h0C
`define TSMS_OFF_NETCMD    8'h10
`define TSMS_OFF_STATUS    8'h14
`define TSMS_OFF_IRQ_STAT  8'h18
`define TSMS_OFF_IRQ_MASK  8'h1C

// Field widths and reset values
`define TSMS_TMO_W         14
`define TSMS_TMO_MAX       14'h270F
`define TSMS_TMO_RST       14'h0001
`define TSMS_FLC_W         16
`define TSMS_FLC_LOW_RST   16'h0064
`define TSMS_FLC_HIGH_RST  16'h0064
`define TSMS_CTRL_RST      4'h0
`define TSMS_IRQ_W         4

// Interrupt event bit positions
`define TSMS_EV_DIAG       0
`define TSMS_EV_UNDERVOLT  1
`define TSMS_EV_SPEED      2
`define TSMS_EV_IGNORED    3

// Timing: one tick is the 0.1 s unit of the transition timeout
`define TSMS_CLK_HZ        125000000
`define TSMS_TICK_MS       100
`define TSMS_LH_DELAY_MS   100

`endif

//--- verilog/tsms_pkg.sv
package tsms_pkg;

`include "tsms_cfg.svh"

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_WAIT = 2'b11
    } tsms_state_e;

    typedef enum logic [1:0] {
        SP_NONE = 2'b00,
        SP_LOW  = 2'b01,
        SP_HIGH = 2'b10
    } tsms_speed_e;

    typedef struct packed {
        logic [`TSMS_ADDR_W-1:0] addr;
        logic [31:0]             wdata;
        logic                    we;
        logic                    re;
    } tsms_bus_s;

    typedef struct packed {
        logic i3_copy;
        logic local_keypad;
        logic impulse;
        logic direct;
    } tsms_ctrl_s;

    typedef struct packed {
        logic stop;
        logic high;
        logic low;
    } tsms_cmd_s;

    typedef struct packed {
        tsms_state_e             fsm;
        tsms_speed_e             dest;
        tsms_speed_e             latch;
        tsms_cmd_s               cmd_prev;
        logic [`TSMS_TMO_W-1:0]  cnt;
        tsms_ctrl_s              ctrl;
        logic [`TSMS_TMO_W-1:0]  timeout;
        logic [`TSMS_FLC_W-1:0]  flc_low;
        logic [`TSMS_FLC_W-1:0]  flc_high;
        logic                    net_fwd;
        logic                    net_low;
        logic                    mem_bit;
        logic [`TSMS_IRQ_W-1:0]  irq_stat;
        logic [`TSMS_IRQ_W-1:0]  irq_mask;
        logic [31:0]             rdata;
        logic                    out_low;
        logic                    out_high;
        logic                    fault_relay;
        logic                    warn;
        logic [`TSMS_FLC_W-1:0]  flc_act;
        logic                    tick_clr;
    } tsms_regs_s;

endpackage

//--- verilog/tsms_tick.sv
`timescale 1ns/100ps
// Restartable divider: one-cycle tick every CYCLES clocks after clr
module tsms_tick #(
    parameter int unsigned CYCLES = 12500000
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic clr,
    output logic      tick
);
    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } tsms_tick_s;

    tsms_tick_s r_reg;
    tsms_tick_s r_next;

    // Count up, wrap and pulse; clr restarts a full period
    always_comb
    begin
        r_next      = r_reg;
        r_next.tick = 1'b0;
        if (clr)
        begin
            r_next.cnt = '0;
        end
        else if (r_reg.cnt == LAST)
        begin
            r_next.cnt  = '0;
            r_next.tick = 1'b1;
        end
        else
        begin
            r_next.cnt = r_reg.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign tick = r_reg.tick;
endmodule

//--- verilog/tsms_top.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "tsms_cfg.svh"
// What this block does
// - The low-speed and high-speed outputs are never on together.
// - Low speed uses the first full-load current, high speed the second.
// - With direct transition off, speed changes only after a stop and a full timeout.
// - With direct transition on, high to low happens by itself after the timeout.
// - On the terminal strip, input 1 drives low speed and input 2 drives high speed.
// - On network with run forward 1, low command 1 picks low, 0 picks high; on keypad, aux 1 picks low and aux 2 high.
// - Input 3 does not steer the motor but can be copied into a memory bit.
// - Low control voltage drops both speed outputs.
// - A diagnostic error drops both speed outputs and the fault relay output.
// - Input 6 selects local control at 0 and remote control at 1.
// - In impulse wiring a low start during the transition timer is ignored.
// - In impulse wiring a low start while stop is active is ignored.
// - The transition timeout runs 0 to 999.9 s and resets to 100 ms.
// - The low-to-high delay is a fixed 100 ms.
// - Commands come from terminal strip, keypad or network.
module tsms_top #(
    parameter int unsigned TICK_CYCLES = `TSMS_CLK_HZ / 1000 * `TSMS_TICK_MS
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire tsms_pkg::tsms_bus_s     bus,
    output logic [31:0]                  rdata,
    input  wire logic [5:0]              logic_in,
    input  wire logic                    key_aux1,
    input  wire logic                    key_aux2,
    input  wire logic                    key_stop,
    input  wire logic                    low_voltage,
    input  wire logic                    diag_err,
    input  wire logic                    warn_in,
    output logic                         out_low_speed,
    output logic                         out_high_speed,
    output logic                         out_warning,
    output logic                         out_fault_relay,
    output logic [`TSMS_FLC_W-1:0]       flc_active,
    output logic                         irq
);
    localparam logic [`TSMS_TMO_W-1:0] LH_TICKS =
        `TSMS_TMO_W'(`TSMS_LH_DELAY_MS / `TSMS_TICK_MS);

    tsms_pkg::tsms_regs_s   r_reg;
    tsms_pkg::tsms_regs_s   r_next;
    tsms_pkg::tsms_cmd_s    cmd;
    tsms_pkg::tsms_cmd_s    rise;
    tsms_pkg::tsms_speed_e  want;
    logic                   tick;
    logic                   remote;
    logic                   fault;
    logic                   imp_mode;
    logic                   blocked;
    logic [`TSMS_IRQ_W-1:0] ev;

    // Write strobe aimed at one register
    function automatic logic is_wr(input tsms_pkg::tsms_bus_s b,
                                   input logic [`TSMS_ADDR_W-1:0] off);
        is_wr = b.we && (b.addr == off);
    endfunction

    // Read data for one address, zero where nothing is mapped
    function automatic logic [31:0] rd_mux(input logic [`TSMS_ADDR_W-1:0] a,
                                           input tsms_pkg::tsms_regs_s s,
                                           input logic rem);
        case (a)
            `TSMS_OFF_CTRL:     rd_mux = {28'h0, s.ctrl};
            `TSMS_OFF_TIMEOUT:  rd_mux = {18'h0, s.timeout};
            `TSMS_OFF_FLC_LOW:  rd_mux = {16'h0, s.flc_low};
            `TSMS_OFF_FLC_HIGH: rd_mux = {16'h0, s.flc_high};
            `TSMS_OFF_NETCMD:   rd_mux = {30'h0, s.net_low, s.net_fwd};
            `TSMS_OFF_STATUS:   rd_mux = {24'h0, s.warn, s.fault_relay, s.mem_bit, rem,
                                          s.out_high, s.out_low, s.fsm};
            `TSMS_OFF_IRQ_STAT: rd_mux = {28'h0, s.irq_stat};
            `TSMS_OFF_IRQ_MASK: rd_mux = {28'h0, s.irq_mask};
            default:            rd_mux = 32'h0;
        endcase
    endfunction

    // Time base for both transition delays
    tsms_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk  (clk),
        .srst (srst),
        .clr  (r_reg.tick_clr),
        .tick (tick)
    );

    // Command source selection and wanted speed
    always_comb
    begin
        remote = logic_in[5];
        fault  = diag_err | low_voltage;
        if (remote)
        begin
            cmd.low  = r_reg.net_fwd & r_reg.net_low;
            cmd.high = r_reg.net_fwd & ~r_reg.net_low;
            cmd.stop = ~r_reg.net_fwd;
        end
        else if (r_reg.ctrl.local_keypad)
        begin
            cmd.low  = key_aux1;
            cmd.high = key_aux2;
            cmd.stop = key_stop;
        end
        else
        begin
            cmd.low  = logic_in[0];
            cmd.high = logic_in[1];
            cmd.stop = r_reg.ctrl.impulse & logic_in[3];
        end
        rise     = cmd & ~r_reg.cmd_prev;
        imp_mode = r_reg.ctrl.impulse & ~remote;
        blocked  = (r_reg.fsm == tsms_pkg::ST_WAIT) | cmd.stop;
        if (imp_mode)
            want = r_reg.latch;
        else if (cmd.low & ~cmd.high & ~cmd.stop)
            want = tsms_pkg::SP_LOW;
        else if (cmd.high & ~cmd.low & ~cmd.stop)
            want = tsms_pkg::SP_HIGH;
        else
            want = tsms_pkg::SP_NONE;
    end

    // Next state: latch, sequencer, outputs, registers
    always_comb
    begin
        r_next          = r_reg;
        r_next.cmd_prev = cmd;
        r_next.tick_clr = 1'b0;
        r_next.rdata    = 32'h0;
        ev              = '0;

        // Impulse latch: start pulses set, stop releases
        if (!imp_mode || fault || cmd.stop)
            r_next.latch = tsms_pkg::SP_NONE;
        else if (rise.low && !blocked)
            r_next.latch = tsms_pkg::SP_LOW;
        else if (rise.high && !blocked)
            r_next.latch = tsms_pkg::SP_HIGH;
        if (imp_mode && (rise.low || rise.high) && blocked)
            ev[`TSMS_EV_IGNORED] = 1'b1;

        // Speed sequencer; any fault forces the motor off
        if (fault)
        begin
            r_next.fsm = tsms_pkg::ST_IDLE;
        end
        else
        begin
            case (r_reg.fsm)
                tsms_pkg::ST_IDLE:
                begin
                    if (want == tsms_pkg::SP_LOW)
                        r_next.fsm = tsms_pkg::ST_LOW;
                    else if (want == tsms_pkg::SP_HIGH)
                        r_next.fsm = tsms_pkg::ST_HIGH;
                end
                tsms_pkg::ST_LOW:
                begin
                    // Maintained: losing the low command stops low speed
                    if (want == tsms_pkg::SP_NONE ||
                        (want == tsms_pkg::SP_HIGH && !r_reg.ctrl.direct && !imp_mode))
                    begin
                        r_next.fsm  = tsms_pkg::ST_WAIT;
                        r_next.dest = tsms_pkg::SP_NONE;
                        r_next.cnt  = r_reg.timeout;
                    end
                    else if (want == tsms_pkg::SP_HIGH && r_reg.ctrl.direct)
                    begin
                        r_next.fsm  = tsms_pkg::ST_WAIT;
                        r_next.dest = tsms_pkg::SP_HIGH;
                        r_next.cnt  = LH_TICKS;
                    end
                end
                tsms_pkg::ST_HIGH:
                begin
                    // Maintained: losing the high command stops high speed
                    if (want == tsms_pkg::SP_NONE ||
                        (want == tsms_pkg::SP_LOW && !r_reg.ctrl.direct && !imp_mode))
                    begin
                        r_next.fsm  = tsms_pkg::ST_WAIT;
                        r_next.dest = tsms_pkg::SP_NONE;
                        r_next.cnt  = r_reg.timeout;
                    end
                    else if (want == tsms_pkg::SP_LOW && r_reg.ctrl.direct)
                    begin
                        r_next.fsm  = tsms_pkg::ST_WAIT;
                        r_next.dest = tsms_pkg::SP_LOW;
                        r_next.cnt  = r_reg.timeout;
                    end
                end
                tsms_pkg::ST_WAIT:
                begin
                    if (want == tsms_pkg::SP_NONE)
                        r_next.dest = tsms_pkg::SP_NONE;
                    if (r_reg.cnt == '0)
                    begin
                        if (r_next.dest == tsms_pkg::SP_LOW)
                            r_next.fsm = tsms_pkg::ST_LOW;
                        else if (r_next.dest == tsms_pkg::SP_HIGH)
                            r_next.fsm = tsms_pkg::ST_HIGH;
                        else
                            r_next.fsm = tsms_pkg::ST_IDLE;
                    end
                    // A tick from before the divider restart is not counted
                    else if (tick && !r_reg.tick_clr)
                    begin
                        r_next.cnt = r_reg.cnt - `TSMS_TMO_W'(1);
                    end
                end
                default:
                begin
                    r_next.fsm = tsms_pkg::ST_IDLE;
                end
            endcase
        end
        if (r_next.fsm == tsms_pkg::ST_WAIT && r_reg.fsm != tsms_pkg::ST_WAIT)
            r_next.tick_clr = 1'b1;

        // Contactor, fault and warning outputs
        r_next.out_low     = (r_next.fsm == tsms_pkg::ST_LOW);
        r_next.out_high    = (r_next.fsm == tsms_pkg::ST_HIGH);
        r_next.fault_relay = ~diag_err;
        r_next.warn        = warn_in;
        if (r_next.fsm == tsms_pkg::ST_LOW)
            r_next.flc_act = r_reg.flc_low;
        else if (r_next.fsm == tsms_pkg::ST_HIGH)
            r_next.flc_act = r_reg.flc_high;
        else
            r_next.flc_act = '0;

        // Input 3 copy into memory bit
        if (r_reg.ctrl.i3_copy)
            r_next.mem_bit = logic_in[2];

        // Event sources
        ev[`TSMS_EV_DIAG]      = diag_err & r_reg.fault_relay;
        ev[`TSMS_EV_UNDERVOLT] = low_voltage & (r_reg.out_low | r_reg.out_high);
        ev[`TSMS_EV_SPEED]     = (r_next.out_low & ~r_reg.out_low) |
                                 (r_next.out_high & ~r_reg.out_high);

        // Register writes
        if (is_wr(bus, `TSMS_OFF_CTRL))
            r_next.ctrl = bus.wdata[3:0];
        if (is_wr(bus, `TSMS_OFF_TIMEOUT))
        begin
            if (bus.wdata > {18'h0, `TSMS_TMO_MAX})
                r_next.timeout = `TSMS_TMO_MAX;
            else
                r_next.timeout = bus.wdata[`TSMS_TMO_W-1:0];
        end
        if (is_wr(bus, `TSMS_OFF_FLC_LOW))
            r_next.flc_low = bus.wdata[`TSMS_FLC_W-1:0];
        if (is_wr(bus, `TSMS_OFF_FLC_HIGH))
            r_next.flc_high = bus.wdata[`TSMS_FLC_W-1:0];
        if (is_wr(bus, `TSMS_OFF_NETCMD))
        begin
            r_next.net_fwd = bus.wdata[0];
            r_next.net_low = bus.wdata[1];
        end
        if (is_wr(bus, `TSMS_OFF_IRQ_MASK))
            r_next.irq_mask = bus.wdata[`TSMS_IRQ_W-1:0];
        // Write one to clear; a new event wins over the clear
        if (is_wr(bus, `TSMS_OFF_IRQ_STAT))
            r_next.irq_stat = r_reg.irq_stat & ~bus.wdata[`TSMS_IRQ_W-1:0];
        r_next.irq_stat = r_next.irq_stat | ev;

        // Read data for the next cycle only
        if (bus.re)
            r_next.rdata = rd_mux(bus.addr, r_reg, remote);
    end

    // State register with reset values
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_reg             <= '0;
            r_reg.fsm         <= tsms_pkg::ST_IDLE;
            r_reg.timeout     <= `TSMS_TMO_RST;
            r_reg.flc_low     <= `TSMS_FLC_LOW_RST;
            r_reg.flc_high    <= `TSMS_FLC_HIGH_RST;
            r_reg.ctrl        <= `TSMS_CTRL_RST;
            r_reg.fault_relay <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flip-flops, except irq, which gates the status bits with the mask
    assign rdata           = r_reg.rdata;
    assign out_low_speed   = r_reg.out_low;
    assign out_high_speed  = r_reg.out_high;
    assign out_warning     = r_reg.warn;
    assign out_fault_relay = r_reg.fault_relay;
    assign flc_active      = r_reg.flc_act;
    assign irq             = |(r_reg.irq_stat & r_reg.irq_mask);

    // Checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_speed_interlock: assert property (!(out_low_speed && out_high_speed))
        else $error("both speed outputs on");
    a_flc_select: assert property (
        (out_high_speed && $stable(r_reg.flc_high)) |-> flc_active == r_reg.flc_high)
        else $error("wrong full-load current at high speed");
    a_no_direct_jump: assert property (
        (!r_reg.ctrl.direct && out_low_speed) |=> !out_high_speed)
        else $error("speed changed without stop and timeout");
    a_direct_hl_wait: assert property (
        (r_reg.fsm == tsms_pkg::ST_HIGH && want == tsms_pkg::SP_LOW && r_reg.ctrl.direct
         && !fault) |=> (r_reg.fsm == tsms_pkg::ST_WAIT && r_reg.cnt == $past(r_reg.timeout)))
        else $error("high to low did not start the timeout");
    a_term_low_start: assert property (
        (!remote && !r_reg.ctrl.local_keypad && !r_reg.ctrl.impulse && logic_in[0]
         && !logic_in[1] && r_reg.fsm == tsms_pkg::ST_IDLE && !fault)
        |=> out_low_speed)
        else $error("input 1 did not start low speed");
    a_net_high_start: assert property (
        (remote && r_reg.net_fwd && !r_reg.net_low && r_reg.fsm == tsms_pkg::ST_IDLE
         && !fault) |=> out_high_speed)
        else $error("network command did not start high speed");
    a_uv_drop: assert property (low_voltage |=> !out_low_speed && !out_high_speed)
        else $error("outputs on under low control voltage");
    a_diag_drop: assert property (
        diag_err |=> !out_low_speed && !out_high_speed && !out_fault_relay)
        else $error("outputs on after diagnostic error");
    a_wait_ignore: assert property (
        (imp_mode && r_reg.fsm == tsms_pkg::ST_WAIT && !cmd.stop && !fault)
        |=> r_reg.latch == $past(r_reg.latch))
        else $error("start accepted during transition timer");
    a_stop_ignore: assert property (imp_mode && cmd.stop |=> r_reg.latch == tsms_pkg::SP_NONE)
        else $error("start accepted while stop active");
    a_lh_fixed: assert property (
        (r_reg.fsm == tsms_pkg::ST_LOW ##1 (r_reg.fsm == tsms_pkg::ST_WAIT
         && r_reg.dest == tsms_pkg::SP_HIGH)) |-> r_reg.cnt == LH_TICKS)
        else $error("low to high delay not fixed");
    a_timeout_exit: assert property (
        (r_reg.fsm == tsms_pkg::ST_WAIT && r_reg.cnt == '0) |=> r_reg.fsm != tsms_pkg::ST_WAIT)
        else $error("transition wait did not end");
endmodule
